/* verilog/cmpctl_top.sv */
// Dual comparator control block: registers, flags and outputs for two
// identical comparators. Assumes analog cores outside, raw outputs async.
//
// Operation
// - Two identical comparator channels; only the first feeds a reset source.
// - Each comparator offers a clock-synchronous latched and a raw output.
// - Raw output keeps following the comparator with the clock stopped.
// - Disabled comparator drives its pin output low and powers down.
// - Result is readable, can raise interrupts and reaches pins.
// - Control bit 7 enables the comparator when one, disables when zero.
// - Control bit 6 reads the current comparator result, read only.
// - Bit 5 sets on rising edges, bit 4 on falling edges.
// - Edge flags stay set until software writes zero to them.
// - Interrupt request per edge only while that edge's enable is one.
// - Control bits 1:0 select negative hysteresis, forwarded to the core.
// - Control bits 3:2 select positive hysteresis, forwarded to the core.
// - Response time setting goes to the core; slower saves current.
// - Mode bits 1:0 select response mode, reset value binary 10.
// - Mode bit 5 rising enable, bit 4 falling enable, rest read zero.
`timescale 1ns/1ps
module cmpctl_top (
  // Clock and reset
  input  wire logic                                sys_clk,
  input  wire logic                                srst,
  // Special register bus
  input  wire cmpctl_pkg::cmpctl_sfr_t             sfr,
  output logic [7:0]                               sfr_rdata,
  // Analog comparator cores
  input  wire logic [1:0]                          raw_in,
  output cmpctl_pkg::cmpctl_ana_t [1:0]            ana,
  // Pin outputs and events
  output logic [1:0]                               latched_out,
  output logic [1:0]                               raw_out,
  output logic [1:0]                               irq_out,
  output logic                                     reset_src_out
);

  logic [7:0] cn_val [2];
  logic [7:0] md_val [2];
  logic [1:0] result;
  logic [1:0] irq_req;
  logic [1:0] wr_cn;
  logic [1:0] wr_md;
  logic [1:0] latched_r;
  logic [1:0] irq_r;
  logic       reset_src_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  function automatic logic [7:0] cn_addr_of(input int unsigned idx);
    cn_addr_of = (idx == 0) ? cmpctl_pkg::CN0_ADDR : cmpctl_pkg::CN1_ADDR;
  endfunction : cn_addr_of

  function automatic logic [7:0] md_addr_of(input int unsigned idx);
    md_addr_of = (idx == 0) ? cmpctl_pkg::MD0_ADDR : cmpctl_pkg::MD1_ADDR;
  endfunction : md_addr_of

  // Both channels are the same logic; only the address differs.
  genvar g;
  generate
    for (g = 0; g < cmpctl_pkg::NUM_CMP; g = g + 1)
    begin : g_chan
      assign wr_cn[g] = sfr.wr && (sfr.addr == cn_addr_of(g));
      assign wr_md[g] = sfr.wr && (sfr.addr == md_addr_of(g));

      cmpctl_chan u_chan (
        .sys_clk (sys_clk),
        .srst    (srst),
        .wr_cn   (wr_cn[g]),
        .wr_md   (wr_md[g]),
        .wdata   (sfr.wdata),
        .raw_in  (raw_in[g]),
        .ana     (ana[g]),
        .cn_val  (cn_val[g]),
        .md_val  (md_val[g]),
        .result  (result[g]),
        .irq_req (irq_req[g])
      );

      // The raw path must work without a clock, so it is not registered.
      assign raw_out[g] = raw_in[g] & ana[g].power_en;
    end
  endgenerate

  // Latched pin output and interrupt requests, one flop after the channel.
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      latched_r <= 2'h0;
      irq_r     <= 2'h0;
    end
    else
    begin
      latched_r <= result;
      irq_r     <= irq_req;
    end
  end

  // Only the first comparator may act as a reset source.
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      reset_src_r <= 1'b0;
    else
      reset_src_r <= result[0];
  end

  // Unmapped addresses read zero so software sees a defined value.
  always_comb
  begin
    rdata_nxt = cmpctl_pkg::RDATA_RESET;
    case (sfr.addr)
      cmpctl_pkg::CN0_ADDR: rdata_nxt = cn_val[0];
      cmpctl_pkg::MD0_ADDR: rdata_nxt = md_val[0];
      cmpctl_pkg::CN1_ADDR: rdata_nxt = cn_val[1];
      cmpctl_pkg::MD1_ADDR: rdata_nxt = md_val[1];
      default:              rdata_nxt = cmpctl_pkg::RDATA_RESET;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      rdata_r <= cmpctl_pkg::RDATA_RESET;
    else if (sfr.rd)
      rdata_r <= rdata_nxt;
  end

  assign sfr_rdata     = rdata_r;
  assign latched_out   = latched_r;
  assign irq_out       = irq_r;
  assign reset_src_out = reset_src_r;

  // The latched pin lags the enable by one flop, so it is checked only once
  // the comparator has been off for a full cycle.
  property p_raw_low_off;
    @(posedge sys_clk) disable iff (srst)
    (!ana[0].power_en && !$past(ana[0].power_en))
      |-> !raw_out[0] && !latched_out[0];
  endproperty
  a_raw_low_off: assert property (p_raw_low_off)
    else $error("Disabled comparator drives its pin high.");

  property p_latched_follows;
    @(posedge sys_clk) disable iff (srst)
    ##1 latched_out == $past(result);
  endproperty
  a_latched_follows: assert property (p_latched_follows)
    else $error("Latched output does not follow the result.");

  property p_irq_masked;
    @(posedge sys_clk) disable iff (srst)
    (wr_md[1] && !sfr.wdata[cmpctl_pkg::MD_RIE_BIT]
              && !sfr.wdata[cmpctl_pkg::MD_FIE_BIT]) |=> ##1 !irq_out[1];
  endproperty
  a_irq_masked: assert property (p_irq_masked)
    else $error("Interrupt raised with both edge enables off.");

  property p_read_result;
    @(posedge sys_clk) disable iff (srst)
    (sfr.rd && sfr.addr == cmpctl_pkg::CN0_ADDR)
      |=> sfr_rdata[cmpctl_pkg::CN_OUT_BIT] == $past(result[0]);
  endproperty
  a_read_result: assert property (p_read_result)
    else $error("Result bit read back wrong.");

  property p_md_unused_zero;
    @(posedge sys_clk) disable iff (srst)
    (sfr.rd && sfr.addr == cmpctl_pkg::MD0_ADDR)
      |=> sfr_rdata[7:6] == 2'h0 && sfr_rdata[3:2] == 2'h0;
  endproperty
  a_md_unused_zero: assert property (p_md_unused_zero)
    else $error("Unused mode bits read nonzero.");

  property p_enable_write;
    @(posedge sys_clk) disable iff (srst)
    wr_cn[0] |=> ana[0].power_en == $past(sfr.wdata[cmpctl_pkg::CN_EN_BIT])
             && ana[0].hyst_pos == $past(sfr.wdata[3:2])
             && ana[0].hyst_neg == $past(sfr.wdata[1:0]);
  endproperty
  a_enable_write: assert property (p_enable_write)
    else $error("Control write not applied to the core.");

  property p_mode_write;
    @(posedge sys_clk) disable iff (srst)
    wr_md[1] |=> ana[1].resp_mode == $past(sfr.wdata[1:0]);
  endproperty
  a_mode_write: assert property (p_mode_write)
    else $error("Response mode not forwarded.");

  c_rise_irq: cover property (@(posedge sys_clk) disable iff (srst)
    $rose(irq_out[0]));
  c_read_cn1: cover property (@(posedge sys_clk) disable iff (srst)
    sfr.rd && sfr.addr == cmpctl_pkg::CN1_ADDR);
  c_reset_src: cover property (@(posedge sys_clk) disable iff (srst)
    $rose(reset_src_out));
  c_clear_flag: cover property (@(posedge sys_clk) disable iff (srst)
    wr_cn[0] && !sfr.wdata[cmpctl_pkg::CN_RIF_BIT]);

endmodule : cmpctl_top

/* verilog/cmpctl_pkg.sv */
// Shared constants and types for the dual comparator control block.
// Assumes an 8-bit special register bus on the system clock.
package cmpctl_pkg;

  // Special register addresses.
  localparam logic [7:0] CN0_ADDR = 8'h9b;
  localparam logic [7:0] MD0_ADDR = 8'h9d;
  localparam logic [7:0] CN1_ADDR = 8'h9a;
  localparam logic [7:0] MD1_ADDR = 8'h9c;

  // Control register field positions.
  localparam int unsigned CN_EN_BIT  = 7;
  localparam int unsigned CN_OUT_BIT = 6;
  localparam int unsigned CN_RIF_BIT = 5;
  localparam int unsigned CN_FIF_BIT = 4;
  localparam int unsigned CN_HYP_LSB = 2;
  localparam int unsigned CN_HYN_LSB = 0;

  // Mode register field positions.
  localparam int unsigned MD_RIE_BIT  = 5;
  localparam int unsigned MD_FIE_BIT  = 4;
  localparam int unsigned MD_MODE_LSB = 0;

  // Reset values.
  localparam logic [7:0] CN_RESET    = 8'h00;
  localparam logic [7:0] MD_RESET    = 8'h02;
  localparam logic [1:0] MODE_RESET  = 2'h2;
  localparam logic [1:0] HYST_RESET  = 2'h0;
  localparam logic [7:0] RDATA_RESET = 8'h00;

  localparam int unsigned NUM_CMP = 2;

  // Settings forwarded to one analog comparator core.
  typedef struct packed {
    logic       power_en;
    logic [1:0] hyst_pos;
    logic [1:0] hyst_neg;
    logic [1:0] resp_mode;
  } cmpctl_ana_t;

  // One special register bus request.
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } cmpctl_sfr_t;

endpackage : cmpctl_pkg

/* verilog/cmpctl_chan.sv */
// One comparator's control and status registers, synchroniser and flags.
// Assumes write strobes already decoded by the parent, raw input async.
`timescale 1ns/1ps
module cmpctl_chan (
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   srst,
  // Register writes
  input  wire logic                   wr_cn,
  input  wire logic                   wr_md,
  input  wire logic [7:0]             wdata,
  // Analog side
  input  wire logic                   raw_in,
  output cmpctl_pkg::cmpctl_ana_t     ana,
  // Status
  output logic [7:0]                  cn_val,
  output logic [7:0]                  md_val,
  output logic                        result,
  output logic                        irq_req
);

  logic       en_r;
  logic       rif_r;
  logic       fif_r;
  logic       rie_r;
  logic       fie_r;
  logic [1:0] hyp_r;
  logic [1:0] hyn_r;
  logic [1:0] md_r;
  logic       sync1_r;
  logic       sync2_r;
  logic       prev_r;
  logic       rise;
  logic       fall;

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      en_r  <= cmpctl_pkg::CN_RESET[cmpctl_pkg::CN_EN_BIT];
      hyp_r <= cmpctl_pkg::HYST_RESET;
      hyn_r <= cmpctl_pkg::HYST_RESET;
    end
    else if (wr_cn)
    begin
      en_r  <= wdata[cmpctl_pkg::CN_EN_BIT];
      hyp_r <= wdata[cmpctl_pkg::CN_HYP_LSB +: 2];
      hyn_r <= wdata[cmpctl_pkg::CN_HYN_LSB +: 2];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      rie_r <= cmpctl_pkg::MD_RESET[cmpctl_pkg::MD_RIE_BIT];
      fie_r <= cmpctl_pkg::MD_RESET[cmpctl_pkg::MD_FIE_BIT];
      md_r  <= cmpctl_pkg::MODE_RESET;
    end
    else if (wr_md)
    begin
      rie_r <= wdata[cmpctl_pkg::MD_RIE_BIT];
      fie_r <= wdata[cmpctl_pkg::MD_FIE_BIT];
      md_r  <= wdata[cmpctl_pkg::MD_MODE_LSB +: 2];
    end
  end

  // The first stage feeds only the second to keep metastability contained.
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r  <= 1'b0;
    end
    else
    begin
      sync1_r <= raw_in;
      sync2_r <= sync1_r;
      prev_r  <= result;
    end
  end

  // A powered-down comparator reads as low, so disabling may flag a fall.
  assign result = sync2_r & en_r;
  assign rise   = en_r & sync2_r & ~prev_r;
  assign fall   = prev_r & ~result;

  // An edge in the same cycle as a clearing write wins over the write.
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      rif_r <= cmpctl_pkg::CN_RESET[cmpctl_pkg::CN_RIF_BIT];
      fif_r <= cmpctl_pkg::CN_RESET[cmpctl_pkg::CN_FIF_BIT];
    end
    else
    begin
      if (rise)
        rif_r <= 1'b1;
      else if (wr_cn)
        rif_r <= wdata[cmpctl_pkg::CN_RIF_BIT];
      if (fall)
        fif_r <= 1'b1;
      else if (wr_cn)
        fif_r <= wdata[cmpctl_pkg::CN_FIF_BIT];
    end
  end

  assign irq_req = (rif_r & rie_r) | (fif_r & fie_r);
  assign cn_val  = {en_r, result, rif_r, fif_r, hyp_r, hyn_r};
  assign md_val  = {2'h0, rie_r, fie_r, 2'h0, md_r};
  assign ana     = '{power_en: en_r, hyst_pos: hyp_r,
                     hyst_neg: hyn_r, resp_mode: md_r};

  property p_rise_sets;
    @(posedge sys_clk) disable iff (srst)
    (en_r && sync2_r && !prev_r) |=> rif_r;
  endproperty
  a_rise_sets: assert property (p_rise_sets)
    else $error("Rising edge did not set the flag.");

  property p_fall_sets;
    @(posedge sys_clk) disable iff (srst)
    (prev_r && !sync2_r) |=> fif_r;
  endproperty
  a_fall_sets: assert property (p_fall_sets)
    else $error("Falling edge did not set the flag.");

  property p_flag_holds;
    @(posedge sys_clk) disable iff (srst)
    (rif_r && !(wr_cn && !wdata[cmpctl_pkg::CN_RIF_BIT])) |=> rif_r;
  endproperty
  a_flag_holds: assert property (p_flag_holds)
    else $error("Rising flag cleared without a clearing write.");

  property p_sync_delay;
    @(posedge sys_clk) disable iff (srst)
    !$past(srst, 2) |-> sync2_r == $past(raw_in, 2);
  endproperty
  a_sync_delay: assert property (p_sync_delay)
    else $error("Synchroniser is not two stages deep.");

  property p_mode_reset;
    @(posedge sys_clk)
    $past(srst) |-> (md_r == cmpctl_pkg::MODE_RESET && !rie_r && !fie_r);
  endproperty
  a_mode_reset: assert property (p_mode_reset)
    else $error("Mode register reset value wrong.");

endmodule : cmpctl_chan

/* test/cmpctl_core_model.sv */
// Behavioural model of one analog comparator core.
// Assumes the bench sets the input level; output changes without a clock.
`timescale 1ns/1ps
module cmpctl_core_model (
  // Settings from the control block
  input  wire cmpctl_pkg::cmpctl_ana_t ana,
  // Input comparison set by the bench
  input  wire logic                    level,
  // Raw result
  output logic                         raw
);
  // An unpowered core has no defined output, so the inverse is driven to
  // expose any missing gating in the control logic.
  assign raw = ana.power_en ? level : ~level;
endmodule : cmpctl_core_model

/* test/testbench.sv */
// Self-checking bench for the dual comparator control block.
// Assumes the core models in cmpctl_core_model and the design package.
`timescale 1ns/1ps
module testbench;
  logic                          sys_clk;
  logic                          srst;
  cmpctl_pkg::cmpctl_sfr_t       sfr;
  logic [7:0]                    sfr_rdata;
  logic [1:0]                    raw_in;
  cmpctl_pkg::cmpctl_ana_t [1:0] ana;
  logic [1:0]                    latched_out;
  logic [1:0]                    raw_out;
  logic [1:0]                    irq_out;
  logic                          reset_src_out;
  logic [1:0]                    lvl;
  logic [15:0]                   lfsr;
  int                            cn_m [2];
  int                            md_m [2];
  int                            fail_count;
  int                            n_tests;

  cmpctl_top uut (.sys_clk(sys_clk), .srst(srst), .sfr(sfr),
    .sfr_rdata(sfr_rdata), .raw_in(raw_in), .ana(ana),
    .latched_out(latched_out), .raw_out(raw_out), .irq_out(irq_out),
    .reset_src_out(reset_src_out));
  cmpctl_core_model core0 (.ana(ana[0]), .level(lvl[0]), .raw(raw_in[0]));
  cmpctl_core_model core1 (.ana(ana[1]), .level(lvl[1]), .raw(raw_in[1]));

  always #50 sys_clk = ~sys_clk;

  function automatic logic [7:0] cn_addr(int i);
    return i ? cmpctl_pkg::CN1_ADDR : cmpctl_pkg::CN0_ADDR;
  endfunction : cn_addr
  function automatic logic [7:0] md_addr(int i);
    return i ? cmpctl_pkg::MD1_ADDR : cmpctl_pkg::MD0_ADDR;
  endfunction : md_addr
  function automatic int res(int i);
    return lvl[i] & cn_m[i][7];
  endfunction : res
  function automatic int exp_cn(int i);
    return (cn_m[i] & 'hbf) | (res(i) << 6);
  endfunction : exp_cn
  function automatic int exp_irq(int i);
    return (cn_m[i][5] & md_m[i][5]) | (cn_m[i][4] & md_m[i][4]);
  endfunction : exp_irq
  function automatic int exp_ana(int i);
    return (cn_m[i][7] << 6) | (((cn_m[i] >> 2) & 3) << 4)
      | ((cn_m[i] & 3) << 2) | (md_m[i] & 3);
  endfunction : exp_ana
  function automatic logic [15:0] lfsr_next(logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr_next

  task automatic cmp8(input logic [7:0] got, input int exp);
    n_tests++;
    if (got !== exp[7:0])
    begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp[7:0]);
    end
  endtask : cmp8
  task automatic chk_reg(input logic [7:0] got, input int exp);
    cmp8(got, exp);
  endtask : chk_reg
  task automatic chk_pin(input logic got, input int exp);
    cmp8({7'h00, got}, exp);
  endtask : chk_pin
  task automatic chk_ana(input logic [6:0] got, input int exp);
    cmp8({1'b0, got}, exp);
  endtask : chk_ana

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    sfr.addr  = a;
    sfr.wdata = d;
    sfr.wr    = 1'b1;
    @(posedge sys_clk);
    #1;
    sfr.wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input int exp);
    @(posedge sys_clk);
    #1;
    sfr.addr = a;
    sfr.rd   = 1'b1;
    @(posedge sys_clk);
    #1;
    sfr.rd = 1'b0;
    chk_reg(sfr_rdata, exp);
  endtask : rd
  // A change of the gated result, by enabling or disabling, is an edge too.
  // A powered-down core shows the inverse level, so enabling on a low input
  // first sees a stale high in the synchroniser: a spurious rise and fall.
  task automatic wr_cn(input int i, input logic [7:0] d);
    int old;
    int was_on;
    old = res(i);
    was_on = cn_m[i][7];
    wr(cn_addr(i), d);
    cn_m[i] = d & 'hbf;
    if (res(i) != old)
      cn_m[i] = cn_m[i] | (res(i) ? 'h20 : 'h10);
    if (!was_on && d[7] && !lvl[i])
      cn_m[i] = cn_m[i] | 'h30;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask : wr_cn
  task automatic wr_md(input int i, input logic [7:0] d);
    wr(md_addr(i), d);
    md_m[i] = d & 'h33;
  endtask : wr_md
  task automatic set_in(input int i, input logic v);
    @(posedge sys_clk);
    #1;
    if (cn_m[i][7] && lvl[i] !== v)
      cn_m[i] = cn_m[i] | (v ? 'h20 : 'h10);
    lvl[i] = v;
    #1;
    chk_pin(raw_out[i], res(i));
    repeat (5) @(posedge sys_clk);
    #1;
    chk_pin(latched_out[i], res(i));
    chk_pin(irq_out[i], exp_irq(i));
    if (i == 0)
      chk_pin(reset_src_out, res(0));
    rd(cn_addr(i), exp_cn(i));
  endtask : set_in

  task automatic results();
    $display("comparisons=%0d mismatches=%0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results

  initial
  begin
    #1_000_000;
    fail_count++;
    results();
  end

  initial
  begin
    sys_clk = 1'b0;
    srst = 1'b1;
    sfr = '0;
    lvl = 2'h0;
    fail_count = 0;
    n_tests = 0;
    lfsr = 16'h5dda;
    cn_m = '{0, 0};
    md_m = '{2, 2};
    repeat (2) @(posedge sys_clk);
    #1;
    srst = 1'b0;
    for (int i = 0; i < 2; i++)
    begin
      rd(cn_addr(i), 'h00);
      rd(md_addr(i), 'h02);
      chk_ana(ana[i], 'h02);
    end
    rd(8'h9e, 'h00);
    wr(8'h9e, 8'hff);
    rd(8'h9e, 'h00);
    repeat (6)
    begin
      for (int i = 0; i < 2; i++)
      begin
        lfsr = lfsr_next(lfsr);
        wr_cn(i, lfsr[7:0]);
        wr_md(i, lfsr[15:8]);
        rd(cn_addr(i), exp_cn(i));
        rd(md_addr(i), md_m[i]);
        chk_ana(ana[i], exp_ana(i));
        chk_pin(irq_out[i], exp_irq(i));
      end
    end
    for (int i = 0; i < 2; i++)
    begin
      wr_md(i, 8'h20);
      wr_cn(i, 8'h80);
      wr_cn(i, 8'h80);
      set_in(i, 1'b1);
      set_in(i, 1'b0);
      wr_cn(i, 8'h80);
      rd(cn_addr(i), exp_cn(i));
      chk_pin(irq_out[i], 0);
      wr_md(i, 8'h10);
      set_in(i, 1'b1);
      set_in(i, 1'b0);
      set_in(i, 1'b1);
      wr_cn(i, 8'h00);
      chk_pin(raw_out[i], 0);
      chk_pin(latched_out[i], 0);
      chk_ana(ana[i], exp_ana(i));
      rd(cn_addr(i), exp_cn(i));
      set_in(i, 1'b0);
      wr_md(i, 8'h00);
      rd(cn_addr(i), exp_cn(i));
      chk_pin(irq_out[i], 0);
      wr_cn(i, 8'h00);
    end
    results();
  end
endmodule : testbench
